// file: src/sdma_master.sv
// DMA bus master that moves sector data between the drive side and memory
`timescale 1ns/10ps
// ****************************************************************
// Functional notes
// ****************************************************************
// Functional notes
// - Sector data moves between drive and memory by DMA, set up by the processor.
// - Up to four drives are addressed, each selected by a two-bit drive number.
// - A read may move a full sector or stop early at any count.
// - A 1024 by 8 bootstrap store answers reads in its address window.
// - Data arrives on data-in lanes and leaves on data-out lanes, selected by direction.
// - As bus master the block asserts address_disable_out.
// - As bus master the block asserts control_disable_out.
// - As bus master the block asserts data_out_disable.
// - Only the grant line picked by the jumper setting is heeded.
// - By default grant line 6 is used.
// - The acknowledge pulse means the grant is valid on the next cycle.
// - A master read asserts the read enable and the slave drives data-in.
// - The block asserts the hold request to obtain the bus.
// - As bus master the block asserts status_disable_out.
// - During DMA the interrupt and cycle-type status lines are held low.
module sdma_master
   import sdma_pkg::*;
#(
   parameter logic [2:0] GRANT_SEL = SDMA_GRANT_DFLT
) (
   // Clock and reset
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   // Transfer setup
   input  wire logic                    start,
   input  wire sdma_pkg::sdma_setup_type setup,
   input  wire logic [1:0]              drive_sel,
   output logic                         busy,
   output logic                         done,
   output logic [3:0]                   drive_select,
   // Drive-side stream toward memory
   input  wire logic                    disk_valid,
   input  wire logic [7:0]              disk_data,
   output logic                         disk_ready,
   // Memory-side stream toward drive
   output logic                         mem_valid,
   output logic [7:0]                   mem_data,
   input  wire logic                    mem_ready,
   // Slave decode for the bootstrap store
   input  wire logic [15:0]             bus_addr,
   input  wire logic                    bus_smemr,
   input  wire logic                    bus_pdbin,
   // Bus pins
   input  wire logic [7:0]              bus_dout_in,
   input  wire logic [7:0]              bus_din_in,
   input  wire logic [7:0]              dma_grant_line,
   input  wire logic                    dma_acknowledge_in,
   output logic                         phold,
   output logic                         address_disable_out,
   output logic                         control_disable_out,
   output logic                         data_out_disable,
   output logic                         status_disable_out,
   output logic                         status_low_oe,
   output sdma_pkg::sdma_master_type    master,
   output logic [7:0]                   bus_din_out,
   output logic                         bus_din_oe
);
   import sdma_pkg::*;

   // ****************************************************************
   // Reset and input synchronisers
   // ****************************************************************
   logic       rst_s1_q, rst_sync_n;
   logic [7:0] grant_s1_q, grant_s2_q;
   logic       ack_s1_q, ack_s2_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_q   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_s1_q   <= 1'b1;
         rst_sync_n <= rst_s1_q;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         grant_s1_q <= 8'h00;
         grant_s2_q <= 8'h00;
         ack_s1_q   <= 1'b0;
         ack_s2_q   <= 1'b0;
      end else begin
         grant_s1_q <= dma_grant_line;
         grant_s2_q <= grant_s1_q;
         ack_s1_q   <= dma_acknowledge_in;
         ack_s2_q   <= ack_s1_q;
      end
   end

   logic my_grant;
   assign my_grant = grant_s2_q[GRANT_SEL];

   // ****************************************************************
   // Two-entry buffer on the drive-to-memory path
   // ****************************************************************
   sdma_word_type buf_q [2];
   logic          wr_ptr_q, rd_ptr_q;
   logic [1:0]    fill_q;
   logic          buf_push, buf_pop, buf_empty;
   sdma_setup_type setup_q;

   assign disk_ready = (fill_q != 2'h2) && busy && setup_q.to_memory;
   assign buf_push   = disk_valid && disk_ready;
   assign buf_empty  = (fill_q == 2'h0);

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         fill_q   <= 2'h0;
      end else begin
         if (buf_push) begin
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (buf_pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         fill_q <= fill_q + {1'b0, buf_push} - {1'b0, buf_pop};
      end
   end

   always_ff @(posedge clock) begin
      if (buf_push) begin
         buf_q[wr_ptr_q] <= '{last: 1'b0, data: disk_data};
      end
   end

   // ****************************************************************
   // Transfer sequencer
   // ****************************************************************
   sdma_state_type state_q;
   logic [15:0]    addr_q;
   logic [15:0]    left_q;
   logic [1:0]     drive_q;
   logic           ack_seen_q;
   logic           abort_q;

   // Grant only counts once the acknowledge pulse was seen a cycle before
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ack_seen_q <= 1'b0;
      end else if (state_q == SDMA_HOLD && ack_s2_q) begin
         ack_seen_q <= 1'b1;
      end else if (state_q == SDMA_IDLE) begin
         ack_seen_q <= 1'b0;
      end
   end

   // Early stop: a new start while busy ends a partial sector read
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         abort_q <= 1'b0;
      end else if (busy && start) begin
         abort_q <= 1'b1;
      end else if (state_q == SDMA_IDLE) begin
         abort_q <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_q <= SDMA_IDLE;
         setup_q <= '0;
         addr_q  <= SDMA_CNT_ZERO;
         left_q  <= SDMA_CNT_ZERO;
         drive_q <= 2'h0;
         done    <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state_q)
            SDMA_IDLE: begin
               if (start && setup.count != SDMA_CNT_ZERO) begin
                  setup_q <= setup;
                  addr_q  <= setup.start_addr;
                  left_q  <= setup.count;
                  drive_q <= drive_sel;
                  state_q <= SDMA_HOLD;
               end
            end
            SDMA_HOLD: begin
               if (ack_s2_q) begin
                  state_q <= SDMA_ACK;
               end else if (abort_q) begin
                  state_q <= SDMA_RELEASE;
               end
            end
            SDMA_ACK: begin
               if (my_grant && ack_seen_q) begin
                  state_q <= SDMA_OWN;
               end
            end
            SDMA_OWN: begin
               if (abort_q || left_q == SDMA_CNT_ZERO) begin
                  state_q <= SDMA_RELEASE;
               end else if (setup_q.to_memory && !buf_empty) begin
                  state_q <= SDMA_WR;
               end else if (!setup_q.to_memory && !mem_valid && !master.pdbin) begin
                  // A read still on the bus would overwrite the held byte
                  state_q <= SDMA_RD;
               end
            end
            SDMA_RD, SDMA_WR: begin
               addr_q  <= sdma_inc(addr_q);
               left_q  <= left_q - SDMA_CNT_ONE;
               state_q <= SDMA_OWN;
            end
            SDMA_RELEASE: begin
               done    <= 1'b1;
               state_q <= SDMA_IDLE;
            end
            default: begin
               state_q <= SDMA_IDLE;
            end
         endcase
      end
   end

   assign busy    = (state_q != SDMA_IDLE);
   assign buf_pop = (state_q == SDMA_WR);

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         drive_select <= 4'h0;
      end else begin
         drive_select <= busy ? (4'h1 << drive_q) : 4'h0;
      end
   end

   // ****************************************************************
   // Bus ownership outputs
   // ****************************************************************
   logic owner;
   assign owner = (state_q == SDMA_OWN) || (state_q == SDMA_RD) || (state_q == SDMA_WR);

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         phold <= 1'b0;
      end else begin
         phold <= (state_q == SDMA_HOLD) || (state_q == SDMA_ACK) || owner;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         address_disable_out <= 1'b0;
         control_disable_out <= 1'b0;
         data_out_disable    <= 1'b0;
         status_disable_out  <= 1'b0;
         status_low_oe       <= 1'b0;
      end else begin
         address_disable_out <= owner;
         control_disable_out <= owner;
         data_out_disable    <= owner;
         status_disable_out  <= owner;
         status_low_oe       <= owner;
      end
   end

   // Master drive group; enable only after grant, never during HOLD/ACK
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         master <= '0;
      end else begin
         master.enable <= owner;
         master.addr   <= addr_q;
         master.smemr  <= (state_q == SDMA_RD);
         master.pdbin  <= (state_q == SDMA_RD);
         master.pwr    <= (state_q == SDMA_WR);
         master.dout   <= buf_q[rd_ptr_q].data;
      end
   end

   // Memory answers on data-in lanes in the same cycle as the read enable
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mem_valid <= 1'b0;
         mem_data  <= 8'h00;
      end else if (master.pdbin) begin
         mem_valid <= 1'b1;
         mem_data  <= bus_din_in;
      end else if (mem_ready) begin
         mem_valid <= 1'b0;
      end
   end

   // ****************************************************************
   // Bootstrap store, slave side
   // ****************************************************************
   logic [7:0] boot_rom [SDMA_BOOT_WORDS];
   logic       boot_hit;

   initial begin
      for (int i = 0; i < SDMA_BOOT_WORDS; i++) begin
         boot_rom[i] = 8'h00;
      end
   end

   assign boot_hit = ((bus_addr & SDMA_BOOT_MASK) == SDMA_BOOT_BASE)
                     && bus_smemr && !owner;

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         bus_din_out <= 8'h00;
         bus_din_oe  <= 1'b0;
      end else begin
         bus_din_out <= boot_rom[bus_addr[SDMA_BOOT_AW-1:0]];
         bus_din_oe  <= boot_hit && bus_pdbin;
      end
   end

endmodule

// file: src/sdma_pkg.sv
// Package: constants and carrier types for the bus-master DMA interface
package sdma_pkg;

   // ****************************************************************
   // Sizes and fixed values
   // ****************************************************************
   localparam int          SDMA_ADDR_W      = 16;
   localparam int          SDMA_DATA_W      = 8;
   localparam int          SDMA_GRANT_N     = 8;
   localparam logic [2:0]  SDMA_GRANT_DFLT  = 3'h6;
   localparam int          SDMA_DRIVE_N     = 4;
   localparam int          SDMA_BOOT_WORDS  = 1024;
   localparam int          SDMA_BOOT_AW     = 10;
   localparam logic [15:0] SDMA_BOOT_BASE   = 16'he000;
   localparam logic [15:0] SDMA_BOOT_MASK   = 16'hfc00;
   localparam int          SDMA_CNT_W       = 16;
   localparam logic [15:0] SDMA_CNT_ONE     = 16'h0001;
   localparam logic [15:0] SDMA_CNT_ZERO    = 16'h0000;

   // ****************************************************************
   // Carrier types
   // ****************************************************************
   typedef enum logic [2:0] {
      SDMA_IDLE    = 3'b000,
      SDMA_HOLD    = 3'b001,
      SDMA_ACK     = 3'b010,
      SDMA_OWN     = 3'b011,
      SDMA_RD      = 3'b100,
      SDMA_WR      = 3'b101,
      SDMA_RELEASE = 3'b110
   } sdma_state_type;

   // Transfer setup from the processor-controlled side
   typedef struct packed {
      logic        to_memory;
      logic [15:0] start_addr;
      logic [15:0] count;
   } sdma_setup_type;

   // Bus-master drive group
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  dout;
      logic        pdbin;
      logic        pwr;
      logic        smemr;
      logic        enable;
   } sdma_master_type;

   // Buffered data word
   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } sdma_word_type;

   function automatic logic [15:0] sdma_inc(input logic [15:0] v);
      return v + 16'h0001;
   endfunction

endpackage

// file: testbench/sdma_chk.sv
// Checker: bus handover assertions for the DMA bus master
`timescale 1ns/10ps
module sdma_chk
   import sdma_pkg::*;
#(
   parameter logic [2:0] GRANT_SEL = SDMA_GRANT_DFLT
) (
   // Clock and reset
   input wire logic                      clock,
   input wire logic                      rst_n,
   // Transfer control
   input wire logic                      start,
   input wire sdma_pkg::sdma_setup_type  setup,
   input wire logic                      busy,
   input wire logic                      done,
   // Bus pins
   input wire logic [7:0]                dma_grant_line,
   input wire logic                      phold,
   input wire logic                      address_disable_out,
   input wire logic                      control_disable_out,
   input wire logic                      data_out_disable,
   input wire logic                      status_disable_out,
   input wire logic                      status_low_oe,
   input wire sdma_pkg::sdma_master_type master
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   // ****************************************************************
   // Handover
   // ****************************************************************
   chk_hold_request: assert property (
      start && !busy && setup.count != 16'h0000 |-> ##2 phold)
      else $error("hold request not raised two cycles after start");
   chk_addr_release: assert property (master.enable |-> address_disable_out)
      else $error("address disable low while driving");
   chk_ctrl_release: assert property (master.enable |-> control_disable_out)
      else $error("control disable low while driving");
   chk_dout_release: assert property (master.enable |-> data_out_disable)
      else $error("data-out disable low while driving");
   chk_status_held: assert property (
      master.enable |-> status_disable_out && status_low_oe)
      else $error("status lines not held while driving");
   chk_grant_first: assert property (
      $rose(master.enable) |-> $past(dma_grant_line[GRANT_SEL], 2) && phold)
      else $error("bus driven without the selected grant");
   chk_read_owner: assert property (master.pdbin |-> master.enable && phold)
      else $error("read enable outside bus ownership");
   // Done rises on the same edge that drops the outputs, as both are registered from the release state
   chk_release_all: assert property (
      done |-> ##[0:2] !phold && !master.enable && !address_disable_out && !status_disable_out)
      else $error("disables still high after completion");
   chk_done_pulse: assert property (done |=> !done)
      else $error("done longer than one cycle");
endmodule

bind sdma_master sdma_chk #(.GRANT_SEL(GRANT_SEL)) chk_i (.clock, .rst_n, .start, .setup,
   .busy, .done, .dma_grant_line, .phold, .address_disable_out, .control_disable_out,
   .data_out_disable, .status_disable_out, .status_low_oe, .master);

// file: testbench/sdma_cpu_model.sv
// Partner: processor grant logic and memory slave on the far side of the bus
`timescale 1ns/10ps
module sdma_cpu_model
   import sdma_pkg::*;
(
   // Clock and reset
   input  wire logic                      clock,
   input  wire logic                      rst_n,
   // Master side
   input  wire logic                      phold,
   input  wire sdma_pkg::sdma_master_type master,
   input  wire logic                      wrong_line,
   // Processor answers
   output logic [7:0]                     dma_grant_line,
   output logic                           dma_acknowledge_in,
   output logic [7:0]                     bus_din_in
);
   logic seen_q, ack_q, grant_q;
   logic [7:0] mem_byte;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         seen_q  <= 1'b0;
         ack_q   <= 1'b0;
         grant_q <= 1'b0;
      end else begin
         seen_q  <= phold;
         ack_q   <= phold && !seen_q;
         grant_q <= phold && (ack_q || grant_q);
      end
   end
   assign dma_acknowledge_in = ack_q;
   // Wrong line lets a scenario prove that other grants are ignored
   assign dma_grant_line = grant_q ? (wrong_line ? 8'h20 : 8'h40) : 8'h00;
   // Released lanes show the inverse so a late sample cannot pass
   assign mem_byte   = master.addr[7:0] ^ 8'h5a;
   assign bus_din_in = master.pdbin ? mem_byte : ~mem_byte;
endmodule

// file: testbench/test_s100_dma_bus_master_interface.sv
// Testbench: DMA bus master against the processor and memory model
`timescale 1ns/10ps
module test_s100_dma_bus_master_interface;
   import sdma_pkg::*;
   logic            clock = 1'b0, rst_n = 1'b0, start = 1'b0, wrong_line = 1'b0;
   logic            disk_valid = 1'b0, mem_ready = 1'b0, bus_smemr = 1'b0, bus_pdbin = 1'b0;
   logic [1:0]      drive_sel = 2'h0;
   logic [7:0]      disk_data = 8'h00;
   logic [15:0]     bus_addr = 16'h0000;
   sdma_setup_type  setup = '0;
   sdma_master_type master;
   logic            busy, done, disk_ready, mem_valid, dma_acknowledge_in, phold, bus_din_oe;
   logic            address_disable_out, control_disable_out, data_out_disable;
   logic            status_disable_out, status_low_oe;
   logic [3:0]      drive_select;
   logic [7:0]      mem_data, dma_grant_line, bus_din_in, bus_din_out;
   int              n_mismatch = 0, check_count = 0;

   always #25 clock = ~clock;

   sdma_master uut (.clock, .rst_n, .start, .setup, .drive_sel, .busy, .done, .drive_select,
      .disk_valid, .disk_data, .disk_ready, .mem_valid, .mem_data, .mem_ready, .bus_addr,
      .bus_smemr, .bus_pdbin, .bus_dout_in(8'h00), .bus_din_in, .dma_grant_line,
      .dma_acknowledge_in, .phold, .address_disable_out, .control_disable_out,
      .data_out_disable, .status_disable_out, .status_low_oe, .master, .bus_din_out,
      .bus_din_oe);
   sdma_cpu_model cpu (.clock, .rst_n, .phold, .master, .wrong_line, .dma_grant_line,
      .dma_acknowledge_in, .bus_din_in);

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task go(input logic tm, input logic [15:0] a, input logic [15:0] n);
      setup = '{tm, a, n};
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
   endtask
   // Takes n bytes off the memory stream and waits for the done pulse
   task collect(input logic [15:0] a, input int n);
      int k, t;
      logic seen;
      logic [15:0] ea;
      k = 0;
      seen = 1'b0;
      // Looks before the edge at which mem_ready takes the byte
      for (t = 0; t < 400 && !(k == n && seen); t++) begin
         if (done === 1'b1) seen = 1'b1;
         if (mem_valid === 1'b1 && k < n) begin
            ea = a + k[15:0];
            check(mem_data, ea[7:0] ^ 8'h5a);
            k++;
         end
         @(negedge clock);
      end
      check(k, n);
      check(seen, 1'b1);
   endtask
   task tally_and_finish;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task t_reset;
      check({phold, address_disable_out, master.enable, bus_din_oe, busy}, 5'h00);
   endtask
   task t_boot;
      bus_smemr = 1'b1;
      bus_pdbin = 1'b1;
      bus_addr = 16'he3ff;
      cyc(3);
      check({bus_din_oe, bus_din_out}, 9'h100);
      bus_addr = 16'he400;
      cyc(3);
      check(bus_din_oe, 1'b0);
      bus_smemr = 1'b0;
      bus_pdbin = 1'b0;
   endtask
   task t_zero;
      go(1'b0, 16'h1000, 16'h0000);
      cyc(8);
      check({busy, phold}, 2'h0);
   endtask
   task t_read;
      mem_ready = 1'b0;
      drive_sel = 2'h2;
      go(1'b0, 16'h10fe, 16'h0003);
      cyc(40);
      check(drive_select, 4'h4);
      check({address_disable_out, control_disable_out, data_out_disable}, 3'h7);
      check({status_disable_out, status_low_oe, master.enable, disk_ready}, 4'he);
      mem_ready = 1'b1;
      collect(16'h10fe, 3);
      cyc(3);
      check({phold, address_disable_out, control_disable_out}, 3'h0);
   endtask
   task t_grant;
      wrong_line = 1'b1;
      go(1'b0, 16'h3000, 16'h0001);
      cyc(30);
      check({phold, address_disable_out, master.enable}, 3'h4);
      wrong_line = 1'b0;
      collect(16'h3000, 1);
   endtask
   task t_write;
      int k, w;
      logic acc, seen;
      k = 0;
      w = 0;
      acc = 1'b0;
      seen = 1'b0;
      go(1'b1, 16'h20ff, 16'h0002);
      fork
         repeat (60) begin
            @(negedge clock);
            if (acc) k++;
            disk_valid = (k < 2);
            disk_data = (k == 0) ? 8'h3c : 8'hc3;
            #1 acc = disk_valid && disk_ready;
         end
         repeat (200) begin
            @(negedge clock);
            if (done === 1'b1) seen = 1'b1;
            if (master.pwr === 1'b1 && w < 2) begin
               check(master.addr, (w == 0) ? 16'h20ff : 16'h2100);
               check(master.dout, (w == 0) ? 8'h3c : 8'hc3);
               w++;
            end
         end
      join
      check({w[1:0], seen}, 3'h5);
   endtask
   task t_abort;
      mem_ready = 1'b0;
      go(1'b0, 16'h4000, 16'h0008);
      cyc(20);
      go(1'b0, 16'h4000, 16'h0008);
      cyc(20);
      check({busy, phold, master.enable}, 3'h0);
      mem_ready = 1'b1;
      cyc(10);
      check(mem_valid, 1'b0);
   endtask

   initial begin
      cyc(6);
      rst_n = 1'b1;
      cyc(4);
      t_reset;
      t_boot;
      t_zero;
      t_read;
      t_grant;
      t_write;
      t_abort;
      tally_and_finish;
   end
   initial begin
      #(50 * 4000);
      n_mismatch++;
      tally_and_finish;
   end
endmodule
